// file: rtl/cmbf_fabric.sv
`timescale 1ns/100ps
`default_nettype none
`include "cmbf_map.svh"
module cmbf_fabric #(
  parameter int PADDR_W = `CMBF_PADDR_W,
  parameter int XADDR_W = `CMBF_XADDR_W
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rstn,
  // Core program side.
  input  wire logic                     prog_rd,
  input  wire logic                     prog_wr,
  input  wire logic [PADDR_W-1:0]       prog_addr,
  output var  logic [15:0]              prog_rdata,
  // Core primary data side.
  input  wire logic                     primary_rd,
  input  wire logic                     primary_wr,
  input  wire logic [1:0]               primary_size,
  input  wire logic [XADDR_W-1:0]       primary_data_addr,
  input  wire logic [31:0]              primary_wdata,
  output var  logic [31:0]              primary_rdata,
  // Core secondary data side.
  input  wire logic                     second_rd,
  input  wire logic [XADDR_W-1:0]       second_data_addr,
  output var  logic [15:0]              second_read_bus,
  // Program flash array.
  output logic                          pflash_rd,
  output logic                          pflash_wr,
  output logic [PADDR_W-1:0]            pflash_addr,
  output logic [15:0]                   pflash_wdata,
  input  wire logic [15:0]              pflash_rdata,
  // Program RAM.
  output logic                          pram_rd,
  output logic                          pram_wr,
  output logic [PADDR_W-1:0]            pram_addr,
  output logic [15:0]                   pram_wdata,
  input  wire logic [15:0]              pram_rdata,
  // Data RAM primary port, 32 bits with size code.
  output logic                          dram_rd,
  output logic                          dram_wr,
  output logic [1:0]                    dram_size,
  output logic [XADDR_W-1:0]            dram_addr,
  output logic [31:0]                   dram_wdata,
  input  wire logic [31:0]              dram_rdata,
  // Data RAM secondary port, word reads only.
  output logic                          dram2_rd,
  output logic [XADDR_W-1:0]            dram2_addr,
  input  wire logic [15:0]              dram2_rdata,
  // Data flash array, 16-bit port.
  output logic                          dflash_rd,
  output logic                          dflash_wr,
  output logic [XADDR_W-1:0]            dflash_addr,
  output logic [15:0]                   dflash_wdata,
  input  wire logic [15:0]              dflash_rdata,
  // Peripheral register bus, 16 bits, flash control included.
  output logic                          periph_rd,
  output logic                          periph_wr,
  output logic [XADDR_W-1:0]            periph_addr,
  output logic [15:0]                   periph_reg_bus,
  input  wire logic [15:0]              periph_rdata
);
  // Address decode shared by both data paths.
  function automatic cmbf_pkg::cmbf_tgt_t decode(
    input logic [XADDR_W-1:0] a
  );
    if ((a & XADDR_W'(`CMBF_PERIPH_MASK)) == XADDR_W'(`CMBF_PERIPH_BASE)) begin
      decode = cmbf_pkg::CMBF_TGT_PERIPH;
    end else if ((a & XADDR_W'(`CMBF_DFLASH_MASK))
                 == XADDR_W'(`CMBF_DFLASH_BASE)) begin
      decode = cmbf_pkg::CMBF_TGT_DFLASH;
    end else begin
      decode = cmbf_pkg::CMBF_TGT_DRAM;
    end
  endfunction

  typedef struct packed {
    logic [15:0]           prog_rdata;
    logic [31:0]           primary_rdata;
    logic [15:0]           second_read_bus;
    logic                  p_ram;
    logic                  p_rd;
    cmbf_pkg::cmbf_tgt_t   x_tgt;
    logic                  x_rd;
    logic                  s_rd;
  } cmbf_st_t;

  cmbf_st_t          st;
  cmbf_st_t          next_st;
  logic              rst_n;
  logic [XADDR_W-1:0] x_addr;
  logic              p_is_ram;
  cmbf_pkg::cmbf_tgt_t x_tgt;
  cmbf_pkg::cmbf_tgt_t s_tgt;

  cmbf_sync_reset u_rst (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .rst_sync_n (rst_n)
  );

  // Byte accesses may only land in the lower half of data space.
  always_comb begin
    x_addr = primary_data_addr;
    if (primary_size == `CMBF_SZ_BYTE) begin
      x_addr[XADDR_W-1] = 1'b0;
    end
  end

  assign p_is_ram = (prog_addr & PADDR_W'(`CMBF_PRAM_MASK))
                    == PADDR_W'(`CMBF_PRAM_BASE);
  assign x_tgt    = decode(x_addr);
  assign s_tgt    = decode(second_data_addr);

  // Program space strobes; writes carry only the low half of write data.
  assign pflash_rd    = prog_rd & ~p_is_ram;
  assign pflash_wr    = prog_wr & ~p_is_ram;
  assign pflash_addr  = prog_addr;
  assign pflash_wdata = primary_wdata[15:0];
  assign pram_rd      = prog_rd & p_is_ram;
  assign pram_wr      = prog_wr & p_is_ram;
  assign pram_addr    = prog_addr;
  assign pram_wdata   = primary_wdata[15:0];

  // Primary data strobes; the data RAM port keeps the full 32 bits.
  assign dram_rd    = primary_rd & (x_tgt == cmbf_pkg::CMBF_TGT_DRAM);
  assign dram_wr    = primary_wr & (x_tgt == cmbf_pkg::CMBF_TGT_DRAM);
  assign dram_size  = primary_size;
  assign dram_addr  = x_addr;
  assign dram_wdata = primary_wdata;

  // Flash contents go straight to the array, 16 bits wide.
  assign dflash_rd    = primary_rd & (x_tgt == cmbf_pkg::CMBF_TGT_DFLASH);
  assign dflash_wr    = primary_wr & (x_tgt == cmbf_pkg::CMBF_TGT_DFLASH);
  assign dflash_addr  = x_addr;
  assign dflash_wdata = primary_wdata[15:0];

  // Peripheral bus is driven in the same cycle, so no wait state exists.
  assign periph_rd      = primary_rd & (x_tgt == cmbf_pkg::CMBF_TGT_PERIPH);
  assign periph_wr      = primary_wr & (x_tgt == cmbf_pkg::CMBF_TGT_PERIPH);
  assign periph_addr    = x_addr;
  assign periph_reg_bus = primary_wdata[15:0];

  // The second path only reads data RAM; other targets are single-ported.
  assign dram2_rd   = second_rd & (s_tgt == cmbf_pkg::CMBF_TGT_DRAM);
  assign dram2_addr = second_data_addr;

  // Capture targets now; memories answer one cycle after the strobe.
  always_comb begin
    next_st       = st;
    next_st.p_rd  = prog_rd;
    next_st.p_ram = p_is_ram;
    next_st.x_rd  = primary_rd;
    next_st.x_tgt = x_tgt;
    next_st.s_rd  = second_rd & (s_tgt == cmbf_pkg::CMBF_TGT_DRAM);
    if (st.p_rd) begin
      next_st.prog_rdata = st.p_ram ? pram_rdata : pflash_rdata;
    end
    if (st.x_rd) begin
      case (st.x_tgt)
        cmbf_pkg::CMBF_TGT_DRAM:   next_st.primary_rdata = dram_rdata;
        cmbf_pkg::CMBF_TGT_DFLASH: next_st.primary_rdata =
                                     {16'h0000, dflash_rdata};
        cmbf_pkg::CMBF_TGT_PERIPH: next_st.primary_rdata =
                                     {16'h0000, periph_rdata};
        default:                   next_st.primary_rdata = dram_rdata;
      endcase
    end
    // Both reads return in the same cycle on their own buses.
    if (st.s_rd) begin
      next_st.second_read_bus = dram2_rdata;
    end
  end

  // State register; data outputs are held until the next read.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign prog_rdata      = st.prog_rdata;
  assign primary_rdata   = st.primary_rdata;
  assign second_read_bus = st.second_read_bus;
endmodule
`default_nettype wire

// file: rtl/cmbf_map.svh
`ifndef CMBF_MAP_SVH
`define CMBF_MAP_SVH
// Bus widths.
`define CMBF_PADDR_W     21
`define CMBF_PDATA_W     16
`define CMBF_XADDR_W     24
`define CMBF_XDATA_W     32
`define CMBF_HALF_W      16
// Address decode: the peripheral window sits at the top of data space.
`define CMBF_PERIPH_BASE 24'hffc000
`define CMBF_PERIPH_MASK 24'hffc000
// Data flash window inside data space.
`define CMBF_DFLASH_BASE 24'h004000
`define CMBF_DFLASH_MASK 24'hffc000
// Program flash versus program RAM: RAM occupies the top of program space.
`define CMBF_PRAM_BASE   21'h1ff800
`define CMBF_PRAM_MASK   21'h1ff800
// Access size codes.
`define CMBF_SZ_BYTE     2'h0
`define CMBF_SZ_WORD     2'h1
`define CMBF_SZ_LONG     2'h2
// Reset value of registered read data.
`define CMBF_RST_DATA    32'h00000000
`endif

// file: rtl/cmbf_pkg.sv
package cmbf_pkg;
  typedef enum logic [1:0] {
    CMBF_TGT_DRAM   = 2'b00,
    CMBF_TGT_DFLASH = 2'b01,
    CMBF_TGT_PERIPH = 2'b11
  } cmbf_tgt_t;
endpackage

// file: rtl/cmbf_sync_reset.sv
`timescale 1ns/100ps
`default_nettype none
// Two-stage release of the asynchronous reset; assertion stays asynchronous.
module cmbf_sync_reset (
  input  wire logic sys_clk,
  input  wire logic rstn,
  output var  logic rst_sync_n
);
  typedef struct packed {
    logic s1;
    logic s2;
  } cmbf_rs_t;
  cmbf_rs_t st;
  cmbf_rs_t next_st;

  // Shift a one in after release.
  always_comb begin
    next_st    = st;
    next_st.s1 = 1'b1;
    next_st.s2 = st.s1;
  end

  // Registered stages.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rst_sync_n = st.s2;
endmodule
`default_nettype wire

// file: testbench/cmbf_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module cmbf_mem_model (
  input  wire logic        sys_clk, pram_rd, pflash_rd, dram_rd,
  input  wire logic        dram2_rd, dflash_rd, periph_rd,
  input  wire logic [20:0] pram_addr, pflash_addr,
  input  wire logic [23:0] dram_addr, dram2_addr, dflash_addr, periph_addr,
  output var  logic [15:0] pram_rdata, pflash_rdata, dram2_rdata,
  output var  logic [15:0] dflash_rdata, periph_rdata,
  output var  logic [31:0] dram_rdata
);
  // Answers one cycle after the strobe; an idle bus inverts every cycle so a
  // sample one cycle late cannot match by luck.
  always_ff @(posedge sys_clk) begin
    pram_rdata <= pram_rd ? pram_addr[15:0] ^ 16'h5a5a : ~pram_rdata;
    pflash_rdata <= pflash_rd ? pflash_addr[15:0] ^ 16'ha5a5 : ~pflash_rdata;
    dram_rdata <= dram_rd ? {~dram_addr[15:0], dram_addr[15:0]} : ~dram_rdata;
    dram2_rdata <= dram2_rd ? dram2_addr[15:0] ^ 16'h3c3c : ~dram2_rdata;
    dflash_rdata <= dflash_rd ? dflash_addr[15:0] ^ 16'h0f0f : ~dflash_rdata;
    periph_rdata <= periph_rd ? periph_addr[15:0] ^ 16'hc3c3 : ~periph_rdata;
  end
endmodule
`default_nettype wire

// file: testbench/cmbf_fabric_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "cmbf_map.svh"
module cmbf_fabric_checker (
  input wire logic        sys_clk, rstn, primary_rd, primary_wr, second_rd,
  input wire logic        pram_rd, pram_wr, dram_rd, dram2_rd, periph_rd,
  input wire logic        periph_wr,
  input wire logic [1:0]  primary_size,
  input wire logic [23:0] primary_data_addr, second_data_addr, dram_addr,
  input wire logic [31:0] primary_wdata, dram_rdata, primary_rdata,
  input wire logic [15:0] pram_wdata, periph_reg_bus, periph_rdata,
  input wire logic [15:0] dram2_rdata, second_read_bus, pram_rdata,
  input wire logic [15:0] prog_rdata
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Byte access aimed at the peripheral window must land in low data RAM.
  byte_msb_a: assert property (
    (primary_rd || primary_wr) && primary_size == `CMBF_SZ_BYTE &&
    (primary_data_addr & `CMBF_PERIPH_MASK) == `CMBF_PERIPH_BASE |->
    !periph_rd && dram_addr == {1'b0, primary_data_addr[22:0]})
    else $error("byte access reached upper half");
  dram_read_a: assert property (
    dram_rd |-> ##2 primary_rdata == $past(dram_rdata))
    else $error("primary read data wrong");
  periph_nowait_a: assert property (
    periph_rd |-> ##2 primary_rdata == {16'h0000, $past(periph_rdata)})
    else $error("peripheral read late or wrong");
  second_read_a: assert property (
    dram2_rd |-> ##2 second_read_bus == $past(dram2_rdata))
    else $error("second read data wrong");
  prog_read_a: assert property (
    pram_rd |-> ##2 prog_rdata == $past(pram_rdata))
    else $error("program read data wrong");
  prog_wlow_a: assert property (
    pram_wr |-> pram_wdata == primary_wdata[15:0])
    else $error("program write data wrong");
  periph_wdata_a: assert property (
    periph_wr |-> periph_reg_bus == primary_wdata[15:0])
    else $error("peripheral write data wrong");
  second_refuse_a: assert property (
    second_rd && (second_data_addr & `CMBF_PERIPH_MASK) == `CMBF_PERIPH_BASE
    |-> !dram2_rd)
    else $error("second path reached peripherals");
  cover property (dram_rd && dram2_rd);
  cover property (periph_wr);
  cover property (pram_rd);
endmodule
`default_nettype wire

// file: testbench/cmbf_fabric_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "cmbf_map.svh"
module cmbf_fabric_tb;
  logic sys_clk, rstn, prog_rd, prog_wr, primary_rd, primary_wr, second_rd;
  logic pflash_rd, pflash_wr, pram_rd, pram_wr, dram_rd, dram_wr, dram2_rd;
  logic dflash_rd, dflash_wr, periph_rd, periph_wr;
  logic [1:0] primary_size, dram_size;
  logic [20:0] prog_addr, pflash_addr, pram_addr;
  logic [23:0] primary_data_addr, second_data_addr, dram_addr, dram2_addr;
  logic [23:0] dflash_addr, periph_addr;
  logic [31:0] primary_wdata, primary_rdata, dram_wdata, dram_rdata;
  logic [15:0] prog_rdata, second_read_bus, pflash_wdata, pflash_rdata;
  logic [15:0] pram_wdata, pram_rdata, dram2_rdata, dflash_wdata;
  logic [15:0] dflash_rdata, periph_reg_bus, periph_rdata;
  int fails = 0;
  int checks = 0;
  cmbf_fabric dut_u (.*);
  cmbf_mem_model mem_u (.*);
  task automatic cmp(string n, logic [31:0] s, logic [31:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // Requests change one step after the edge and drop after the next one.
  task automatic step(bit clr);
    @(posedge sys_clk);
    #1;
    if (clr) {prog_rd, prog_wr, primary_rd, primary_wr, second_rd} = '0;
  endtask
  task automatic t_prog();
    prog_rd = 1; prog_addr = 21'h1ff810;
    #1 cmp("pram_rd", pram_rd, 1);
    step(0); prog_addr = 21'h000123;
    step(1); cmp("prog_rdata", prog_rdata, 16'ha24a);
    step(0); cmp("prog_rdata", prog_rdata, 16'ha486);
    prog_wr = 1; prog_addr = 21'h1ff800; primary_wdata = 32'hdead1234;
    #1 cmp("pram_wdata", pram_wdata, 16'h1234);
    cmp("pram_wr", {pram_wr, pflash_wr}, 2'b10);
    step(1);
  endtask
  task automatic t_periph();
    primary_wr = 1; primary_size = `CMBF_SZ_WORD;
    primary_data_addr = 24'hffc004; primary_wdata = 32'h5555abcd;
    #1 cmp("periph_reg_bus", periph_reg_bus, 16'habcd);
    cmp("periph_addr", periph_addr, 24'hffc004);
    step(0); primary_wr = 0; primary_rd = 1;
    step(1); step(0);
    cmp("primary_rdata", primary_rdata, 32'h000003c7);
  endtask
  task automatic t_dual();
    primary_rd = 1; primary_size = `CMBF_SZ_LONG;
    primary_data_addr = 24'h000100; second_rd = 1; second_data_addr = 24'h200;
    #1 cmp("dram_size", dram_size, `CMBF_SZ_LONG);
    cmp("dram2_addr", dram2_addr, 24'h000200);
    step(1); step(0);
    cmp("primary_rdata", primary_rdata, 32'hfeff0100);
    cmp("second_read_bus", second_read_bus, 16'h3e3c);
    primary_rd = 1; primary_size = `CMBF_SZ_BYTE; primary_data_addr = 24'hffc010;
    second_rd = 1; second_data_addr = 24'hffc000;
    #1 cmp("dram_addr", dram_addr, 24'h7fc010);
    cmp("dram2_rd", dram2_rd, 0);
    step(1); step(0);
    cmp("second_read_bus", second_read_bus, 16'h3e3c);
    cmp("primary_rdata", primary_rdata, 32'h3fefc010);
  endtask
  task automatic t_dflash();
    primary_rd = 1; primary_size = `CMBF_SZ_WORD; primary_data_addr = 24'h004020;
    #1 cmp("dflash_rd", {dflash_rd, periph_rd}, 2'b10);
    step(1); step(0);
    cmp("primary_rdata", primary_rdata, 32'h00004f2f);
    primary_wr = 1; primary_wdata = 32'h9876fedc;
    #1 cmp("dflash_wdata", {dflash_wr, dflash_wdata}, 17'h1fedc);
    primary_data_addr = 24'h000400;
    #1 cmp("dram_wdata", dram_wdata, 32'h9876fedc);
    cmp("dram_wr", {dram_wr, dflash_wr}, 2'b10);
    step(1);
  endtask
  task automatic final_report();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    sys_clk = 0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // A hang is cut short well beyond the few dozen cycles the run needs.
  initial begin
    #20000;
    fails++;
    final_report();
  end
  initial begin
    rstn = 0; {prog_rd, prog_wr, primary_rd, primary_wr, second_rd} = '0;
    prog_addr = '0; primary_size = '0; primary_data_addr = '0;
    primary_wdata = '0; second_data_addr = '0;
    repeat (8) @(posedge sys_clk);
    #1 rstn = 1;
    repeat (3) step(0);
    t_prog(); t_periph(); t_dual(); t_dflash();
    final_report();
  end
endmodule
bind cmbf_fabric cmbf_fabric_checker chk_u (.*);
`default_nettype wire
